// ==== pkg/ptom_defs.svh ====
`ifndef PTOM_DEFS_SVH
`define PTOM_DEFS_SVH
// Register byte offsets
`define PTOM_OFF_CTRL    12'h000
`define PTOM_OFF_PERIOD  12'h004
`define PTOM_OFF_COUNT   12'h008
`define PTOM_OFF_STATUS  12'h00C
`define PTOM_OFF_MASK    12'h010
// Control fields
`define PTOM_CTRL_RUN    0
`define PTOM_CTRL_LO_LSB 1
`define PTOM_CTRL_HI_LSB 4
`define PTOM_CTRL_PS_LSB 8
`define PTOM_CTRL_FRZ    12
// Status bits
`define PTOM_ST_POST     0
`define PTOM_ST_MATCH    1
// Values
`define PTOM_PERIOD_RST  8'hFF
`define PTOM_HI_ONESHOT  2'h1
`define PTOM_HI_MONO     2'h2
// Lower mode codes
`define PTOM_LO_SW       3'h0
`define PTOM_LO_RISE     3'h1
`define PTOM_LO_FALL     3'h2
`define PTOM_LO_ANY      3'h3
`define PTOM_LO_RISE_RST 3'h4
`define PTOM_LO_FALL_RST 3'h5
`define PTOM_LO_LVL_HIGH 3'h6
`define PTOM_LO_LVL_LOW  3'h7
`define PTOM_SYNC_STAGES 2
`endif

// ==== pkg/ptom_pkg.sv ====
package ptom_pkg;
	typedef struct packed {
		logic       freeze;
		logic [3:0] postscale_select;
		logic [1:0] mode_hi;
		logic [2:0] mode_lo;
		logic       run;
	} ptom_ctrl_s;
	typedef enum logic [1:0] {
		PTOM_IDLE,
		PTOM_ARMED,
		PTOM_COUNT
	} ptom_state_e;
endpackage : ptom_pkg

// ==== hdl/ptom_sync.sv ====
`timescale 1ns/1ps
`include "ptom_defs.svh"
module ptom_sync (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Level in and out
	input  wire logic d_in,
	output logic      d_out
);
	logic [`PTOM_SYNC_STAGES-1:0] stage_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			stage_reg <= '0;
		else
			stage_reg <= {stage_reg[`PTOM_SYNC_STAGES-2:0], d_in};
	end
	assign d_out = stage_reg[`PTOM_SYNC_STAGES-1];
endmodule : ptom_sync

// ==== hdl/ptom_timer.sv ====
// What this block does
// RL1: Upper 01 lower 000: count starts as soon as run is set.
// RL2: One-shot: clock after match clears run, count held at zero.
// RL3: Codes 001/010/011 start on rising, falling or any source edge.
// RL4: Edge modes need a fresh edge after run set; levels ignored.
// RL5: Codes 100/101 start on an edge; in one-shot the same edge later resets count.
// RL6: Code 110 rising start, low resets; 111 falling start, high resets.
// RL7: Monostable edge start; after match count holds zero, run stays.
// RL8: Monostable 110 counts while source high, else held at zero; 111 inverse.
// RL9: Interrupt when postscaler count equals the 1:1..1:16 ratio.
// RL10: Interrupt forwarded only when enable mask bit is set.
// RL11: Flag is sticky, set within two cycles, cleared by software.
// RL12: Run bit and reset source pass a two-stage synchroniser.
// RL13: Count increments each tick; cleared on tick after match.
// RL14: Source keeps six ticks between edges, three for levels.
// RL15: Source triggers ignored while debug freeze is active.
// RL16: Reserved mode encodings are undefined; software avoids them.
`timescale 1ns/1ps
`include "ptom_defs.svh"
module ptom_timer (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timer
	input  wire logic        timer_clock,
	input  wire logic        ext_reset_source,
	output logic             postscaled_pulse,
	output logic             irq
);
	ptom_pkg::ptom_ctrl_s   ctrl_reg;
	ptom_pkg::ptom_state_e  state_reg;
	ptom_pkg::ptom_state_e  state_next;
	logic [7:0]  period_value_reg;
	logic [7:0]  count_value_reg;
	logic [7:0]  count_next;
	logic [3:0]  post_cnt_reg;
	logic [1:0]  status_reg;
	logic [1:0]  periph_irq_enable_reg;
	logic        ers_prev_reg;
	logic        pulse_reg;
	logic        match_reg;
	logic        ers_s;
	logic        run_s;
	////////////////////////////////////////////////////////////////////////
	// Synchronisers
	ptom_sync u_sync_ers ( // RL12
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d_in    (ext_reset_source),
		.d_out   (ers_s)
	);
	ptom_sync u_sync_run ( // RL12
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d_in    (ctrl_reg.run),
		.d_out   (run_s)
	);
	////////////////////////////////////////////////////////////////////////
	// APB decode
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit
	// Control word as software sees it; the struct packs it tighter
	function automatic logic [31:0] ctrl_word(input ptom_pkg::ptom_ctrl_s c);
		ctrl_word                         = 32'h0;
		ctrl_word[`PTOM_CTRL_RUN]         = c.run;
		ctrl_word[`PTOM_CTRL_LO_LSB +: 3] = c.mode_lo;
		ctrl_word[`PTOM_CTRL_HI_LSB +: 2] = c.mode_hi;
		ctrl_word[`PTOM_CTRL_PS_LSB +: 4] = c.postscale_select;
		ctrl_word[`PTOM_CTRL_FRZ]         = c.freeze;
	endfunction : ctrl_word
	function automatic ptom_pkg::ptom_ctrl_s ctrl_field(input logic [31:0] w);
		ctrl_field.run              = w[`PTOM_CTRL_RUN];
		ctrl_field.mode_lo          = w[`PTOM_CTRL_LO_LSB +: 3];
		ctrl_field.mode_hi          = w[`PTOM_CTRL_HI_LSB +: 2];
		ctrl_field.postscale_select = w[`PTOM_CTRL_PS_LSB +: 4];
		ctrl_field.freeze           = w[`PTOM_CTRL_FRZ];
	endfunction : ctrl_field
	// Lower-code groups, asked by several decoders below
	function automatic logic code_rise(input logic [2:0] c);
		case (c)
			`PTOM_LO_RISE, `PTOM_LO_RISE_RST, `PTOM_LO_LVL_HIGH: begin
				code_rise = 1'b1;
			end
			default: begin
				code_rise = 1'b0;
			end
		endcase
	endfunction : code_rise
	function automatic logic code_fall(input logic [2:0] c);
		case (c)
			`PTOM_LO_FALL, `PTOM_LO_FALL_RST, `PTOM_LO_LVL_LOW: begin
				code_fall = 1'b1;
			end
			default: begin
				code_fall = 1'b0;
			end
		endcase
	endfunction : code_fall
	function automatic logic code_level(input logic [2:0] c);
		case (c)
			`PTOM_LO_LVL_HIGH, `PTOM_LO_LVL_LOW: begin
				code_level = 1'b1;
			end
			default: begin
				code_level = 1'b0;
			end
		endcase
	endfunction : code_level
	wire acc      = psel && penable;
	wire wr       = acc && pwrite;
	wire wr_ctrl  = wr && hit(paddr, `PTOM_OFF_CTRL);
	wire wr_per   = wr && hit(paddr, `PTOM_OFF_PERIOD);
	wire wr_cnt   = wr && hit(paddr, `PTOM_OFF_COUNT);
	wire wr_stat  = wr && hit(paddr, `PTOM_OFF_STATUS);
	wire wr_mask  = wr && hit(paddr, `PTOM_OFF_MASK);
	wire mapped   = hit(paddr, `PTOM_OFF_CTRL) || hit(paddr, `PTOM_OFF_PERIOD)
		|| hit(paddr, `PTOM_OFF_COUNT) || hit(paddr, `PTOM_OFF_STATUS)
		|| hit(paddr, `PTOM_OFF_MASK);
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	wire [31:0] rd_mux =
		hit(paddr, `PTOM_OFF_CTRL)   ? ctrl_word(ctrl_reg) :
		hit(paddr, `PTOM_OFF_PERIOD) ? {24'h0, period_value_reg} :
		hit(paddr, `PTOM_OFF_COUNT)  ? {24'h0, count_value_reg} :
		hit(paddr, `PTOM_OFF_STATUS) ? {30'h0, status_reg} :
		hit(paddr, `PTOM_OFF_MASK)   ? {30'h0, periph_irq_enable_reg} :
		32'h0;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end
	////////////////////////////////////////////////////////////////////////
	// Tick and trigger decode
	logic tclk_prev_reg;
	// Timer clock must stay below half of clk_sys or ticks are lost
	wire tick     = timer_clock && !tclk_prev_reg;                      // RL13
	wire [1:0] hi = ctrl_reg.mode_hi;
	wire [2:0] lo = ctrl_reg.mode_lo;
	wire oneshot  = (hi == `PTOM_HI_ONESHOT);
	wire mono     = (hi == `PTOM_HI_MONO);
	// Freeze holds the last level, so no edge can show meanwhile
	wire ers_eff  = ctrl_reg.freeze ? ers_prev_reg : ers_s;             // RL15
	wire rise     = ers_eff && !ers_prev_reg;
	wire fall     = !ers_eff && ers_prev_reg;
	wire any_code = (lo == `PTOM_LO_ANY);
	// Software start needs no edge at all
	wire start_ev = (code_rise(lo) && rise)                      // RL3 RL5 RL6
		|| (code_fall(lo) && fall)                               // RL3 RL5 RL6
		|| (any_code && (rise || fall));                                // RL3
	wire edge_rst = oneshot && ((lo == `PTOM_LO_RISE_RST && rise)
		|| (lo == `PTOM_LO_FALL_RST && fall));                          // RL5
	// Level codes: high level is the go level for code 110, low for 111
	wire hi_code  = (lo == `PTOM_LO_LVL_HIGH);
	wire lvl_go   = hi_code ? ers_eff : !ers_eff;
	wire lvl_rst  = oneshot && code_level(lo) && !lvl_go;               // RL6
	wire mono_lvl = mono && code_level(lo);
	wire mono_go  = lvl_go;                                             // RL8
	wire match    = (count_value_reg == period_value_reg);
	wire ps_hit   = (post_cnt_reg == ctrl_reg.postscale_select);          // RL9
	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		state_next = state_reg;
		count_next = count_value_reg;
		case (state_reg)
			ptom_pkg::PTOM_IDLE: begin
				// A run bit that hardware just cleared is still in the sync
				if (run_s && ctrl_reg.run)
					state_next = (lo == `PTOM_LO_SW || mono_lvl) ?
						ptom_pkg::PTOM_COUNT : ptom_pkg::PTOM_ARMED;     // RL1 RL4
			end
			ptom_pkg::PTOM_ARMED: begin
				if (start_ev)
					state_next = ptom_pkg::PTOM_COUNT;                   // RL3 RL7
			end
			ptom_pkg::PTOM_COUNT: begin
				if (mono_lvl && !mono_go)
					count_next = 8'h00;                                   // RL8
				else if (edge_rst || lvl_rst)
					count_next = 8'h00;                                   // RL5 RL6
				else if (tick && match) begin
					count_next = 8'h00;                                   // RL13
					if (!mono_lvl)
						state_next = oneshot ?
							ptom_pkg::PTOM_IDLE : ptom_pkg::PTOM_ARMED;  // RL2 RL7
				end else if (tick)
					count_next = count_value_reg + 8'h01;                 // RL13
			end
			default: state_next = ptom_pkg::PTOM_IDLE;
		endcase
		if (!run_s || !(oneshot || mono)) begin
			state_next = ptom_pkg::PTOM_IDLE;                             // RL2
			if (state_reg != ptom_pkg::PTOM_IDLE)
				count_next = 8'h00;
		end
		if (wr_cnt)
			count_next = pwdata[7:0];
	end
	wire ended    = oneshot && state_reg == ptom_pkg::PTOM_COUNT
		&& state_next == ptom_pkg::PTOM_IDLE && run_s;
	wire per_ev   = (state_reg == ptom_pkg::PTOM_COUNT) && tick && match;
	wire ps_clr   = wr_cnt || wr_ctrl || edge_rst || lvl_rst;
	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg         <= '0;
			period_value_reg <= `PTOM_PERIOD_RST;
			count_value_reg  <= 8'h00;
			state_reg        <= ptom_pkg::PTOM_IDLE;
			tclk_prev_reg    <= 1'b0;
			ers_prev_reg     <= 1'b0;
		end else begin
			tclk_prev_reg   <= timer_clock;
			ers_prev_reg    <= ers_eff;
			state_reg       <= state_next;
			count_value_reg <= count_next;
			if (wr_ctrl)
				ctrl_reg <= ctrl_field(pwdata);
			else if (ended)
				ctrl_reg.run <= 1'b0;                                     // RL2
			if (wr_per)
				period_value_reg <= pwdata[7:0];
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			post_cnt_reg <= 4'h0;
			pulse_reg    <= 1'b0;
			match_reg    <= 1'b0;
		end else begin
			pulse_reg <= 1'b0;
			match_reg <= per_ev;
			if (ps_clr)
				post_cnt_reg <= 4'h0;
			else if (per_ev) begin
				if (ps_hit) begin
					post_cnt_reg <= 4'h0;
					pulse_reg    <= 1'b1;                                 // RL9
				end else
					post_cnt_reg <= post_cnt_reg + 4'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over clear
	wire [1:0] ev = {match_reg, pulse_reg};
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status_reg            <= 2'h0;
			periph_irq_enable_reg <= 2'h0;
		end else begin
			status_reg <= (status_reg & ~(wr_stat ? pwdata[1:0] : 2'h0))
				| ev;                                                     // RL11
			if (wr_mask)
				periph_irq_enable_reg <= pwdata[1:0];
		end
	end
	assign postscaled_pulse = pulse_reg;
	assign irq = |(status_reg & periph_irq_enable_reg);                   // RL10
endmodule : ptom_timer

// ==== dv/ptom_src_model.sv ====
`timescale 1ns/1ps
module ptom_src_model (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Level asked for by the bench
	input  wire logic want,
	// Toward the timer
	output logic      timer_clock,
	output logic      ext_reset_source
);
	logic [1:0] div_reg;
	logic [4:0] hold_reg;
	assign timer_clock = div_reg[1];
	// Holds each level 24 cycles, six ticks, so no trigger is too close
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 2'h0;
			hold_reg <= 5'h0;
			ext_reset_source <= 1'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (hold_reg != 5'h0) begin
				hold_reg <= hold_reg - 5'h1;
			end else if (want != ext_reset_source) begin
				ext_reset_source <= want;
				hold_reg <= 5'h18;
			end
		end
	end
endmodule : ptom_src_model

// ==== dv/ptom_timer_asserts.sv ====
`timescale 1ns/1ps
`include "ptom_defs.svh"
module ptom_timer_asserts (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// Timer
	input  wire logic        postscaled_pulse,
	input  wire logic        irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic       wr;
	logic [1:0] msk_reg;
	logic       run_reg;
	assign wr = psel && penable && pwrite;
	// Shadows only what software wrote; hardware may clear run earlier
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			msk_reg <= 2'h0;
			run_reg <= 1'h0;
		end else if (wr && paddr == `PTOM_OFF_MASK) begin
			msk_reg <= pwdata[1:0];
		end else if (wr && paddr == `PTOM_OFF_CTRL) begin
			run_reg <= pwdata[0];
		end
	end
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_stopped;
		!run_reg [*8];
	endsequence
	AST_ACCESS: assert property (s_access |-> pready)
		else $error("access phase without ready");
	AST_NOERR: assert property (!psel |-> !pslverr)
		else $error("error response while idle");
	AST_SLVERR: assert property (psel && penable && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > `PTOM_OFF_MASK))
		else $error("error response wrong for address");
	AST_PULSE: assert property (postscaled_pulse |=> !postscaled_pulse)
		else $error("postscaled pulse longer than one cycle");
	AST_IRQ_SET: assert property (
		postscaled_pulse && msk_reg[0] |-> ##[0:2] irq)
		else $error("irq late after postscale event");
	AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(wr))
		else $error("irq dropped without software write");
	AST_IRQ_MASK: assert property (
		msk_reg == 2'h0 && $past(msk_reg) == 2'h0 |-> !irq)
		else $error("irq with all sources masked");
	AST_STOP: assert property (s_stopped |-> !postscaled_pulse)
		else $error("pulse while run is clear");
endmodule : ptom_timer_asserts
bind ptom_timer ptom_timer_asserts ptom_timer_asserts_inst (
	.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .postscaled_pulse(postscaled_pulse), .irq(irq));

// ==== dv/ptom_timer_tb_top.sv ====
`timescale 1ns/1ps
`include "ptom_defs.svh"
module ptom_timer_tb_top;
	// Flags: check run, start level, edge level, match a, match b, run
	typedef struct packed {
		logic [15:0] ctrl;
		logic [5:0]  f;
	} ptom_row_s;
	logic        clk_sys = 1'h0;
	logic        rstn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        want = 1'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, irq;
	logic        timer_clock, ext_reset_source, postscaled_pulse;
	int          fail_count = 0;
	int          checks = 0;
	int          cyc = 0;
	int          pulses = 0;
	int          p0 = 0;
	// The rows never set a reserved encoding; only the ctrl readback check writes upper code 11
	ptom_row_s   rows [14] = '{'{16'h0011, 6'h24}, '{16'h0013, 6'h2A},
		'{16'h0015, 6'h32}, '{16'h0017, 6'h32}, '{16'h0019, 6'h2A},
		'{16'h001B, 6'h32}, '{16'h001D, 6'h2A}, '{16'h001F, 6'h32},
		'{16'h0023, 6'h2B}, '{16'h0025, 6'h33}, '{16'h0027, 6'h2B},
		'{16'h002D, 6'h0A}, '{16'h002F, 6'h12}, '{16'h1013, 6'h29}};
	ptom_timer ptom_timer_inst (.clk_sys(clk_sys), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_clock(timer_clock),
		.ext_reset_source(ext_reset_source),
		.postscaled_pulse(postscaled_pulse), .irq(irq));
	ptom_src_model ptom_src_model_inst (.clk_sys(clk_sys), .rstn(rstn),
		.want(want), .timer_clock(timer_clock),
		.ext_reset_source(ext_reset_source));
	always #10 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////
	task close_out;
		if (fail_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		while (pready !== 1'h1) begin
			@(posedge clk_sys);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys);
	endtask : apb
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (postscaled_pulse === 1'h1)
			pulses <= pulses + 1;
		if (cyc == 8000) begin
			fail_count++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		apb(1'h0, `PTOM_OFF_PERIOD, 32'h0);
		chk("period", 32'h0000_00FF, rd);
		apb(1'h0, 12'h014, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		apb(1'h1, `PTOM_OFF_PERIOD, 32'h3);
		foreach (rows[i]) begin
			apb(1'h1, `PTOM_OFF_CTRL, 32'h0);
			apb(1'h1, `PTOM_OFF_COUNT, 32'h0);
			want <= rows[i].f[4];
			repeat (40) @(posedge clk_sys);
			apb(1'h1, `PTOM_OFF_STATUS, 32'h3);
			apb(1'h1, `PTOM_OFF_CTRL, {16'h0, rows[i].ctrl});
			repeat (40) @(posedge clk_sys);
			apb(1'h0, `PTOM_OFF_STATUS, 32'h0);
			chk("match_a", {31'h0, rows[i].f[2]}, {31'h0, rd[1]});
			apb(1'h1, `PTOM_OFF_STATUS, 32'h3);
			want <= rows[i].f[3];
			repeat (40) @(posedge clk_sys);
			apb(1'h0, `PTOM_OFF_STATUS, 32'h0);
			chk("match_b", {31'h0, rows[i].f[1]}, {31'h0, rd[1]});
			apb(1'h0, `PTOM_OFF_CTRL, 32'h0);
			if (rows[i].f[5]) begin
				chk("run", {31'h0, rows[i].f[0]}, {31'h0, rd[0]});
			end
		end
		apb(1'h1, `PTOM_OFF_CTRL, 32'h0);
		apb(1'h1, `PTOM_OFF_MASK, 32'h1);
		want <= 1'h1;
		apb(1'h1, `PTOM_OFF_CTRL, 32'h0F2D);
		apb(1'h1, `PTOM_OFF_STATUS, 32'h3);
		p0 = pulses;
		repeat (100) @(posedge clk_sys);
		chk("irq_early", 32'h0, {31'h0, irq});
		repeat (600) @(posedge clk_sys);
		chk("irq_late", 32'h1, {31'h0, irq});
		chk("pulse_seen", 32'h1, {31'h0, pulses > p0});
		apb(1'h1, `PTOM_OFF_CTRL, 32'h0);
		apb(1'h1, `PTOM_OFF_MASK, 32'h0);
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1'h1, `PTOM_OFF_MASK, 32'h1);
		chk("irq_unmasked", 32'h1, {31'h0, irq});
		apb(1'h1, `PTOM_OFF_STATUS, 32'h1);
		chk("irq_cleared", 32'h0, {31'h0, irq});
		apb(1'h1, `PTOM_OFF_COUNT, 32'h55);
		apb(1'h0, `PTOM_OFF_COUNT, 32'h0);
		chk("count_load", 32'h55, rd);
		apb(1'h1, `PTOM_OFF_CTRL, 32'h1F3F);
		apb(1'h0, `PTOM_OFF_CTRL, 32'h0);
		chk("ctrl_rb", 32'h1F3F, rd);
		// Mid-run reset must restore period and control
		rstn <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		apb(1'h0, `PTOM_OFF_PERIOD, 32'h0);
		chk("period_rst", 32'h0000_00FF, rd);
		apb(1'h0, `PTOM_OFF_CTRL, 32'h0);
		chk("ctrl_rst", 32'h0, rd);
		close_out();
	end
endmodule : ptom_timer_tb_top
